// ===== bench/cssp_clock_ctrl_tb.sv
`timescale 1ns/1ps
module cssp_clock_ctrl_tb;
  localparam int LIMIT = 20000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  cssp_pkg::cssp_fuse_t fuses = '0;
  logic [7:0] cal = 8'h00;
  logic sleep_req = 1'b0;
  logic wake_req = 1'b0;
  logic wdt_osc, hready, hresp, div_en, cpu_en, pin, pin_oe_n;
  logic tosc_allow, tosc_ext, running, cfg_err;
  logic [31:0] hrdata;
  logic [7:0] trim;
  cssp_pkg::cssp_src_t kind;
  logic rd_phase = 1'b0;
  logic [31:0] exp_q[$];
  int num_errors = 0;
  int check_count = 0;
  int cyc = 0;
  int n, m;
  logic [31:0] v;

  // The source clock never changes its period.
  always #4 clk = ~clk;

  cssp_osc_model #(.HALF_NS(20)) i_cssp_osc_model (.o_wdt_osc(wdt_osc));

  // Long counts shortened so the long start-up path runs in a few cycles.
  cssp_clock_ctrl
  #(
    .WDT_LONG_CYCLES(17'h0_0010),
    .WAKE_LF_LONG_CYCLES(17'h0_0028),
    .WAKE_XTAL_CYCLES(17'h0_0014)
  )
  i_cssp_clock_ctrl
  (
    .I_SYS_CLK(clk), .I_RESET(rst), .I_HSEL(hsel), .I_HADDR(haddr),
    .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2),
    .I_HWDATA(hwdata), .I_HREADY(hready), .O_HRDATA(hrdata),
    .O_HREADYOUT(hready), .O_HRESP(hresp), .I_FUSES(fuses),
    .I_FACTORY_CAL(cal), .I_SLEEP_REQ(sleep_req), .I_WAKE_REQ(wake_req),
    .I_WDT_OSC(wdt_osc), .O_DIV_CLK_EN(div_en), .O_CPU_CLK_EN(cpu_en),
    .O_CLOCK_OUTPUT_PIN(pin), .O_CLOCK_OUTPUT_PIN_OE_N(pin_oe_n),
    .O_RC_TRIM(trim), .O_SRC_KIND(kind), .O_TIMER_OSC_ALLOW(tosc_allow),
    .O_TOSC_EXT_CLOCK(tosc_ext), .O_RUNNING(running),
    .O_CONFIG_ERROR(cfg_err)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("Checks %0d, errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  function automatic cssp_pkg::cssp_src_t exp_kind(input logic [3:0] c);
    if (c[3])
      return cssp_pkg::SRC_XTAL;
    if (c == 4'h6 || c == 4'h7)
      return cssp_pkg::SRC_LF;
    if (c == 4'h2)
      return cssp_pkg::SRC_RC;
    if (c == 4'h0)
      return cssp_pkg::SRC_EXT;
    return cssp_pkg::SRC_BAD;
  endfunction

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      num_errors++;
      print_verdict();
    end
  end

  // Read data is judged at the edge that closes the data phase.
  always @(posedge clk)
    if (rd_phase && hready === 1'b1 && exp_q.size() > 0)
      check(hrdata, exp_q.pop_front());

  // One single transfer; for a read, d is the expected word.
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    @(posedge clk);
    while (hready !== 1'b1)
      @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    rd_phase <= ~wr;
    if (!wr)
      exp_q.push_back(d);
    @(posedge clk);
    while (hready !== 1'b1)
      @(posedge clk);
    check(hresp, 1'b0);
    rd_phase <= 1'b0;
  endtask

  task automatic do_reset(input cssp_pkg::cssp_fuse_t f);
    @(posedge clk);
    rst <= 1'b1;
    fuses <= f;
    cal <= 8'($urandom);
    repeat (2) @(posedge clk);
    #1;
    check(pin_oe_n, 1'b0);
    check(running, 1'b0);
    @(posedge clk);
    rst <= 1'b0;
  endtask

  task automatic wait_run(output int cnt);
    cnt = 0;
    while (running !== 1'b1 && cnt < 2000)
    begin
      @(posedge clk);
      #1;
      cnt++;
    end
  endtask

  task automatic en_gap(output int cnt);
    cnt = 0;
    repeat (600)
    begin
      @(posedge clk);
      #1;
      if (div_en === 1'b1)
        break;
    end
    do
    begin
      @(posedge clk);
      #1;
      cnt++;
    end
    while (div_en !== 1'b1 && cnt < 600);
  endtask

  task automatic pin_high(output int cnt);
    cnt = 0;
    while (pin !== 1'b0 && cnt < 600)
    begin
      @(posedge clk);
      #1;
      cnt++;
    end
    cnt = 0;
    while (pin !== 1'b1 && cnt < 600)
    begin
      @(posedge clk);
      #1;
      cnt++;
    end
    cnt = 0;
    while (pin === 1'b1 && cnt < 600)
    begin
      @(posedge clk);
      #1;
      cnt++;
    end
  endtask

  initial
  begin
    v = $urandom(82);
    for (int c = 0; c < 16; c++)
    begin
      do_reset('{4'(c), 2'h0, 1'b0, 1'b0});
      repeat (3) @(posedge clk);
      #1;
      check(kind, exp_kind(4'(c)));
      check(tosc_allow, 4'(c) == 4'h2);
      check(cfg_err, exp_kind(4'(c)) == cssp_pkg::SRC_BAD);
      check(pin_oe_n, 1'b1);
    end
    do_reset('{4'h6, 2'h0, 1'b0, 1'b0});
    wait_run(n);
    check(n >= 4 && n <= 9, 1'b1);
    do_reset('{4'h2, 2'h2, 1'b0, 1'b0});
    wait_run(n);
    check(n >= 88 && n <= 106, 1'b1);
    do_reset('{4'h2, 2'h0, 1'b1, 1'b1});
    wait_run(n);
    check(n >= 14 && n <= 19, 1'b1);
    check(trim, cal);
    check(pin_oe_n, 1'b0);
    bus(1'b0, 8'h00, 32'h0000_0003);
    bus(1'b0, 8'h0C, 32'h0000_0221);
    bus(1'b0, 8'h10, 32'h0000_0000);
    v = {24'h00_0000, 8'($urandom)};
    bus(1'b1, 8'h04, v);
    bus(1'b0, 8'h04, v);
    check(trim, v[7:0]);
    bus(1'b1, 8'h08, 32'h0000_0001);
    @(posedge clk);
    #1;
    check(tosc_ext, 1'b1);
    en_gap(n);
    check(n, 8);
    pin_high(n);
    check(n, 4);
    @(posedge clk);
    sleep_req <= 1'b1;
    @(posedge clk);
    sleep_req <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    check(running, 1'b0);
    check(cpu_en, 1'b0);
    @(posedge clk);
    wake_req <= 1'b1;
    @(posedge clk);
    wake_req <= 1'b0;
    wait_run(n);
    check(n >= 5 && n <= 10, 1'b1);
    m = 8;
    for (int s = 0; s < 9; s++)
    begin
      if (s > 2 && s < 8)
        continue;
      bus(1'b1, 8'h00, 32'h0000_0080);
      bus(1'b1, 8'h00, 32'(s));
      bus(1'b0, 8'h00, 32'(s));
      en_gap(n);
      check(n >= ((m < (1 << s)) ? m : (1 << s)), 1'b1);
      en_gap(n);
      check(n, 1 << s);
      m = 1 << s;
    end
    bus(1'b1, 8'h00, 32'h0000_0081);
    bus(1'b1, 8'h00, 32'h0000_0005);
    bus(1'b0, 8'h00, 32'h0000_0008);
    bus(1'b1, 8'h00, 32'h0000_0080);
    bus(1'b1, 8'h00, 32'h0000_0009);
    repeat (6) @(posedge clk);
    bus(1'b0, 8'h00, 32'h0000_0008);
    bus(1'b1, 8'h00, 32'h0000_0080);
    repeat (8) @(posedge clk);
    bus(1'b1, 8'h00, 32'h0000_0001);
    bus(1'b0, 8'h00, 32'h0000_0008);
    repeat (2) @(posedge clk);
    print_verdict();
  end
endmodule // cssp_clock_ctrl_tb

// ===== bench/cssp_osc_model.sv
`timescale 1ns/1ps
// The watchdog oscillator is kept well below a third of the system clock.
// Otherwise the three-flop synchroniser in the block would drop edges.
module cssp_osc_model
#(
  parameter int HALF_NS = 20
)
(
  // Oscillator output.
  output logic o_wdt_osc
);
  initial
  begin
    o_wdt_osc = 1'b0;
    #7;
    forever
    begin
      #(HALF_NS) o_wdt_osc = ~o_wdt_osc;
    end
  end
endmodule // cssp_osc_model

// ===== src/cssp_clock_ctrl.sv
// Chosen here: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
module cssp_clock_ctrl
#(
  parameter logic [16:0] WDT_LONG_CYCLES = 17'h1_0000,
  parameter logic [16:0] WAKE_LF_LONG_CYCLES = 17'h8000,
  parameter logic [16:0] WAKE_XTAL_CYCLES = 17'h4000
)
(
  // Clock and reset.
  input wire logic I_SYS_CLK,
  input wire logic I_RESET,
  // AHB-Lite slave.
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  output logic [31:0] O_HRDATA,
  output logic O_HREADYOUT,
  output logic O_HRESP,
  // Fuses, factory trim, sleep control and watchdog oscillator.
  input wire cssp_pkg::cssp_fuse_t I_FUSES,
  input wire logic [7:0] I_FACTORY_CAL,
  input wire logic I_SLEEP_REQ,
  input wire logic I_WAKE_REQ,
  input wire logic I_WDT_OSC,
  // Clock outputs.
  output logic O_DIV_CLK_EN,
  output logic O_CPU_CLK_EN,
  output logic O_CLOCK_OUTPUT_PIN,
  output logic O_CLOCK_OUTPUT_PIN_OE_N,
  // Oscillator control and status.
  output logic [7:0] O_RC_TRIM,
  output cssp_pkg::cssp_src_t O_SRC_KIND,
  output logic O_TIMER_OSC_ALLOW,
  output logic O_TOSC_EXT_CLOCK,
  output logic O_RUNNING,
  output logic O_CONFIG_ERROR
);

  function automatic logic [7:0] div_last(input logic [3:0] sel);
    logic [8:0] f;
    f = 9'h001 << sel;
    div_last = 8'(f - 9'h001);
  endfunction

  function automatic cssp_pkg::cssp_src_t src_decode(input logic [3:0] c);
    cssp_pkg::cssp_src_t k;
    k = cssp_pkg::SRC_BAD;
    if (c[3])
      k = cssp_pkg::SRC_XTAL;
    else if (c == cssp_pkg::CODE_LF_SHORT || c == cssp_pkg::CODE_LF_LONG)
      k = cssp_pkg::SRC_LF;
    else if (c == cssp_pkg::CODE_RC)
      k = cssp_pkg::SRC_RC;
    else if (c == cssp_pkg::CODE_EXT)
      k = cssp_pkg::SRC_EXT;
    return k;
  endfunction

  cssp_pkg::cssp_fuse_t fuse;
  cssp_pkg::cssp_src_t src_kind;
  cssp_pkg::cssp_state_t state;
  cssp_pkg::cssp_aphase_t aph;
  logic fuse_loaded;
  logic cfg_err;
  logic [3:0] sel_reg;
  logic [3:0] div_sel;
  logic [7:0] div_cnt;
  logic wrap;
  logic [7:0] next_cnt;
  logic [7:0] next_last;
  logic next_phase;
  logic ce;
  logic [1:0] ce_cnt;
  logic [7:0] rc_trim;
  logic async_ext;
  logic [16:0] cnt;
  logic [16:0] rst_target;
  logic [16:0] wdt_target;
  logic [16:0] wake_target;
  logic wdt_s1;
  logic wdt_s2;
  logic wdt_s3;
  logic wdt_lvl;
  logic wdt_tick;
  logic wr_div;
  logic wr_trim;
  logic wr_async;
  logic div_set_ce;
  logic div_write_sel;

  default clocking dc @(posedge I_SYS_CLK);
  endclocking
  default disable iff (I_RESET);

  // Fuses are straps: caught on the first edge after reset release.
  always_ff @(posedge I_SYS_CLK or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      fuse <= '0;
      fuse_loaded <= 1'b0;
      src_kind <= cssp_pkg::SRC_BAD;
    end
    else if (!fuse_loaded)
    begin
      fuse <= I_FUSES;
      fuse_loaded <= 1'b1;
      src_kind <= src_decode(I_FUSES.src_sel);
    end
  end

  // A reserved start-up code is only legal for the crystal source.
  always_comb
  begin
    cfg_err = (src_kind == cssp_pkg::SRC_BAD) ||
              (src_kind != cssp_pkg::SRC_XTAL &&
               fuse.startup_time_fuses == cssp_pkg::SUT_RSVD);
  end

  // Data-phase write strobes.
  always_comb
  begin
    wr_div = aph.valid && aph.write && aph.addr == cssp_pkg::ADDR_DIV_CTRL;
    wr_trim = aph.valid && aph.write && aph.addr == cssp_pkg::ADDR_RC_TRIM;
    wr_async = aph.valid && aph.write &&
               aph.addr == cssp_pkg::ADDR_ASYNC_STATUS;
    div_set_ce = wr_div && I_HWDATA[cssp_pkg::CE_BIT] &&
                 I_HWDATA[6:0] == 7'h00;
    div_write_sel = wr_div && !I_HWDATA[cssp_pkg::CE_BIT];
  end

  // AHB-Lite slave: zero wait states, always OKAY.
  always_ff @(posedge I_SYS_CLK or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      aph <= '0;
      O_HRDATA <= 32'h0000_0000;
      O_HREADYOUT <= 1'b1;
      O_HRESP <= 1'b0;
    end
    else
    begin
      aph.valid <= I_HSEL && I_HTRANS[1] && I_HREADY;
      aph.write <= I_HWRITE;
      aph.addr <= I_HADDR[7:0];
      O_HRDATA <= 32'h0000_0000;
      if (I_HSEL && I_HTRANS[1] && I_HREADY && !I_HWRITE)
      begin
        unique case (I_HADDR[7:0])
          cssp_pkg::ADDR_DIV_CTRL:
            O_HRDATA <= {24'h00_0000, ce, 3'h0, sel_reg};
          cssp_pkg::ADDR_RC_TRIM:
            O_HRDATA <= {24'h00_0000, rc_trim};
          cssp_pkg::ADDR_ASYNC_STATUS:
            O_HRDATA <= {31'h0000_0000, async_ext};
          cssp_pkg::ADDR_CLOCK_STATUS:
            O_HRDATA <= {20'h0_0000, fuse.src_sel, 1'b0, src_kind,
                         2'h0, cfg_err, state == cssp_pkg::ST_RUN};
          default:
            O_HRDATA <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Change enable: set only by a lone enable write; a second one while
  // open neither extends nor clears it, so software cannot hold it open.
  always_ff @(posedge I_SYS_CLK or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      ce <= 1'b0;
      ce_cnt <= 2'h0;
    end
    else if (!ce)
    begin
      if (div_set_ce)
      begin
        ce <= 1'b1;
        ce_cnt <= 2'h0;
      end
    end
    else if (div_write_sel || ce_cnt == cssp_pkg::CE_LAST)
    begin
      ce <= 1'b0;
    end
    else
    begin
      ce_cnt <= ce_cnt + 2'h1;
    end
  end

  // Requested divider select; reserved values are dropped.
  always_ff @(posedge I_SYS_CLK or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      sel_reg <= cssp_pkg::SEL_RESET;
    end
    else if (!fuse_loaded)
    begin
      sel_reg <= I_FUSES.div8 ? cssp_pkg::SEL_DIV8 :
                 cssp_pkg::SEL_RESET;
    end
    else if (ce && div_write_sel && I_HWDATA[3:0] <= cssp_pkg::SEL_MAX)
    begin
      sel_reg <= I_HWDATA[3:0];
    end
  end

  // Divider on the undivided clock. A new select is taken only when the
  // running period ends, so no period is ever shorter than old or new.
  always_comb
  begin
    wrap = div_cnt == div_last(div_sel);
    next_cnt = wrap ? 8'h00 : div_cnt + 8'h01;
    next_last = div_last(wrap ? sel_reg : div_sel);
    if (next_last == 8'h00)
      next_phase = !O_CLOCK_OUTPUT_PIN;
    else
      next_phase = next_cnt <= (next_last >> 1);
  end

  always_ff @(posedge I_SYS_CLK or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      div_sel <= cssp_pkg::SEL_RESET;
      div_cnt <= 8'h00;
    end
    else if (!fuse_loaded)
    begin
      div_sel <= I_FUSES.div8 ? cssp_pkg::SEL_DIV8 :
                 cssp_pkg::SEL_RESET;
      div_cnt <= 8'h00;
    end
    else
    begin
      div_cnt <= next_cnt;
      if (wrap)
        div_sel <= sel_reg;
    end
  end

  // Divided clock enables for the synchronous domains.
  always_ff @(posedge I_SYS_CLK or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      O_DIV_CLK_EN <= 1'b0;
      O_CPU_CLK_EN <= 1'b0;
    end
    else
    begin
      O_DIV_CLK_EN <= wrap && fuse_loaded;
      O_CPU_CLK_EN <= wrap && fuse_loaded &&
                      state == cssp_pkg::ST_RUN;
    end
  end

  // Clock output pin. The pin is driven through reset; the clock itself
  // only starts toggling once the straps are caught.
  always_ff @(posedge I_SYS_CLK or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      O_CLOCK_OUTPUT_PIN <= 1'b0;
      O_CLOCK_OUTPUT_PIN_OE_N <= 1'b0;
    end
    else if (fuse_loaded)
    begin
      O_CLOCK_OUTPUT_PIN <= fuse.clk_out && next_phase;
      O_CLOCK_OUTPUT_PIN_OE_N <= !fuse.clk_out;
    end
  end

  // Trim register: factory value first, then software may retune.
  logic trim_loaded;
  always_ff @(posedge I_SYS_CLK or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      rc_trim <= cssp_pkg::TRIM_RESET;
      trim_loaded <= 1'b0;
    end
    else if (!trim_loaded)
    begin
      rc_trim <= I_FACTORY_CAL;
      trim_loaded <= 1'b1;
    end
    else if (wr_trim)
    begin
      rc_trim <= I_HWDATA[7:0];
    end
  end

  always_ff @(posedge I_SYS_CLK or posedge I_RESET)
  begin
    if (I_RESET)
      async_ext <= 1'b0;
    else if (wr_async)
      async_ext <= I_HWDATA[cssp_pkg::ASYNC_EXT_BIT];
  end

  // Oscillator routing outputs.
  always_ff @(posedge I_SYS_CLK or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      O_RC_TRIM <= cssp_pkg::TRIM_RESET;
      O_SRC_KIND <= cssp_pkg::SRC_BAD;
      O_TIMER_OSC_ALLOW <= 1'b0;
      O_TOSC_EXT_CLOCK <= 1'b0;
      O_RUNNING <= 1'b0;
      O_CONFIG_ERROR <= 1'b0;
    end
    else
    begin
      O_RC_TRIM <= rc_trim;
      O_SRC_KIND <= src_kind;
      O_TIMER_OSC_ALLOW <= src_kind == cssp_pkg::SRC_RC;
      O_TOSC_EXT_CLOCK <= src_kind == cssp_pkg::SRC_RC &&
                          async_ext;
      O_RUNNING <= state == cssp_pkg::ST_RUN;
      O_CONFIG_ERROR <= fuse_loaded && cfg_err;
    end
  end

  // Watchdog oscillator crosses in through three flops; a level counts
  // only once the last two agree, which rejects a single-sample glitch.
  always_ff @(posedge I_SYS_CLK or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      wdt_s1 <= 1'b0;
      wdt_s2 <= 1'b0;
      wdt_s3 <= 1'b0;
      wdt_lvl <= 1'b0;
    end
    else
    begin
      wdt_s1 <= I_WDT_OSC;
      wdt_s2 <= wdt_s1;
      wdt_s3 <= wdt_s2;
      if (wdt_s2 == wdt_s3)
        wdt_lvl <= wdt_s3;
    end
  end

  always_comb
  begin
    wdt_tick = wdt_s2 && wdt_s3 && !wdt_lvl;
  end

  // Delay targets from the straps.
  always_comb
  begin
    rst_target = (src_kind == cssp_pkg::SRC_LF) ?
                 cssp_pkg::RST_LF_CYCLES :
                 cssp_pkg::RST_OTHER_CYCLES;
    wdt_target = (fuse.startup_time_fuses == cssp_pkg::SUT_SHORT) ?
                 cssp_pkg::WDT_SHORT_CYCLES : WDT_LONG_CYCLES;
    unique case (src_kind)
      cssp_pkg::SRC_LF:
        wake_target = fuse.src_sel[0] ? WAKE_LF_LONG_CYCLES :
                      cssp_pkg::WAKE_LF_SHORT_CYCLES;
      cssp_pkg::SRC_XTAL:
        wake_target = WAKE_XTAL_CYCLES;
      default:
        wake_target = cssp_pkg::WAKE_FAST_CYCLES;
    endcase
  end

  // Start-up timer: source cycles, then watchdog cycles unless the start-up code is SUT_NONE, then run.
  always_ff @(posedge I_SYS_CLK or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      state <= cssp_pkg::ST_SRC;
      cnt <= 17'h0_0000;
    end
    else
    begin
      unique case (state)
        cssp_pkg::ST_SRC:
          if (fuse_loaded && !cfg_err)
          begin
            if (cnt == rst_target - 17'h0_0001)
            begin
              cnt <= 17'h0_0000;
              state <= (fuse.startup_time_fuses == cssp_pkg::SUT_NONE) ?
                       cssp_pkg::ST_RUN : cssp_pkg::ST_WDT;
            end
            else
              cnt <= cnt + 17'h0_0001;
          end
        cssp_pkg::ST_WDT:
          if (wdt_tick)
          begin
            if (cnt == wdt_target - 17'h0_0001)
            begin
              cnt <= 17'h0_0000;
              state <= cssp_pkg::ST_RUN;
            end
            else
              cnt <= cnt + 17'h0_0001;
          end
        cssp_pkg::ST_RUN:
          if (I_SLEEP_REQ)
            state <= cssp_pkg::ST_SLEEP;
        cssp_pkg::ST_SLEEP:
          if (I_WAKE_REQ)
          begin
            cnt <= 17'h0_0000;
            state <= cssp_pkg::ST_WAKE;
          end
        cssp_pkg::ST_WAKE:
          if (cnt == wake_target - 17'h0_0001)
          begin
            cnt <= 17'h0_0000;
            state <= cssp_pkg::ST_RUN;
          end
          else
            cnt <= cnt + 17'h0_0001;
        default:
          state <= cssp_pkg::ST_SRC;
      endcase
    end
  end

  ce_window_a: assert property ($rose(ce) |-> ##[1:4] !ce)
    else $error("change enable stayed open past four cycles");

  sel_legal_a: assert property (div_sel <= cssp_pkg::SEL_MAX)
    else $error("reserved divider select applied");

  switch_edge_a: assert property (
    $past(fuse_loaded) && $changed(div_sel) |-> $past(wrap))
    else $error("divider select changed inside a period");

  new_period_a: assert property (
    fuse_loaded && wrap && sel_reg != div_sel |=>
      div_cnt == 8'h00 && div_sel == $past(sel_reg))
    else $error("new divider period did not start cleanly");

  cpu_gate_a: assert property (
    O_CPU_CLK_EN |-> $past(state) == cssp_pkg::ST_RUN)
    else $error("cpu clock enabled before start-up finished");

  // Keyed on the load itself, so the edge that releases reset is not
  // mistaken for a missed load.
  trim_load_a: assert property (
    $rose(trim_loaded) |-> rc_trim == $past(I_FACTORY_CAL))
    else $error("factory trim not loaded");

  // The register and the output flop each add one edge.
  trim_write_a: assert property (
    trim_loaded && wr_trim |=>
      ##1 O_RC_TRIM == $past(I_HWDATA[7:0], 2))
    else $error("trim write did not reach the oscillator");

  tosc_allow_a: assert property (
    O_TIMER_OSC_ALLOW |-> $past(src_kind) == cssp_pkg::SRC_RC)
    else $error("timer oscillator allowed without RC source");

  clkout_drive_a: assert property (
    fuse_loaded && fuse.clk_out |=> !O_CLOCK_OUTPUT_PIN_OE_N)
    else $error("clock output pin not driven");

  wake_fast_a: assert property (
    state == cssp_pkg::ST_SLEEP && I_WAKE_REQ &&
    (src_kind == cssp_pkg::SRC_RC || src_kind == cssp_pkg::SRC_EXT) |=>
      (state == cssp_pkg::ST_WAKE) [*6] ##1
      state == cssp_pkg::ST_RUN)
    else $error("fast wake did not take six cycles");

endmodule // cssp_clock_ctrl

// ===== src/cssp_pkg.sv
package cssp_pkg;

  // Register byte offsets on the AHB-Lite slave.
  localparam logic [7:0] ADDR_DIV_CTRL = 8'h00;
  localparam logic [7:0] ADDR_RC_TRIM = 8'h04;
  localparam logic [7:0] ADDR_ASYNC_STATUS = 8'h08;
  localparam logic [7:0] ADDR_CLOCK_STATUS = 8'h0C;

  // Field positions.
  localparam int CE_BIT = 7;
  localparam int ASYNC_EXT_BIT = 0;
  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_ERR_BIT = 1;
  localparam int STAT_SRC_LSB = 4;

  // Clock source select fuse codes.
  localparam logic [3:0] CODE_LF_SHORT = 4'h6;
  localparam logic [3:0] CODE_LF_LONG = 4'h7;
  localparam logic [3:0] CODE_RC = 4'h2;
  localparam logic [3:0] CODE_EXT = 4'h0;

  // Start-up time fuse codes.
  localparam logic [1:0] SUT_NONE = 2'h0;
  localparam logic [1:0] SUT_SHORT = 2'h1;
  localparam logic [1:0] SUT_RSVD = 2'h3;

  // Divider select values and reset values.
  localparam logic [3:0] SEL_MAX = 4'h8;
  localparam logic [3:0] SEL_DIV8 = 4'h3;
  localparam logic [3:0] SEL_RESET = 4'h0;
  localparam logic [7:0] TRIM_RESET = 8'h00;
  localparam logic [1:0] CE_LAST = 2'h3;

  // Counts in source clock cycles or watchdog oscillator cycles.
  localparam logic [16:0] RST_LF_CYCLES = 17'h0004;
  localparam logic [16:0] RST_OTHER_CYCLES = 17'h000E;
  localparam logic [16:0] WAKE_FAST_CYCLES = 17'h0006;
  localparam logic [16:0] WAKE_LF_SHORT_CYCLES = 17'h0400;
  localparam logic [16:0] WDT_SHORT_CYCLES = 17'h1000;

  typedef enum logic [2:0]
  {
    SRC_XTAL = 3'h0,
    SRC_LF = 3'h1,
    SRC_RC = 3'h2,
    SRC_EXT = 3'h3,
    SRC_BAD = 3'h4
  } cssp_src_t;

  typedef enum logic [2:0]
  {
    ST_SRC = 3'b000,
    ST_WDT = 3'b001,
    ST_RUN = 3'b011,
    ST_SLEEP = 3'b010,
    ST_WAKE = 3'b110
  } cssp_state_t;

  typedef struct packed
  {
    logic [3:0] src_sel;
    logic [1:0] startup_time_fuses;
    logic div8;
    logic clk_out;
  } cssp_fuse_t;

  typedef struct packed
  {
    logic valid;
    logic write;
    logic [7:0] addr;
  } cssp_aphase_t;

endpackage
